// [dv/buzzer_melody_sound_generator_tb_top.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t got %0h exp %0h", $time, a, b); end end
module buzzer_melody_sound_generator_tb_top;
  localparam logic [3:0] AC = sga_pkg::ADDR_CLOCK;
  localparam logic [3:0] AM = sga_pkg::ADDR_MODE;
  localparam logic [3:0] AT = sga_pkg::ADDR_CTRL;
  localparam logic [3:0] AD = sga_pkg::ADDR_DATA;
  localparam logic [3:0] AF = sga_pkg::ADDR_FLAG;
  logic        ref_clk, reset, reg_wr, reg_rd, debug_mode, clr;
  logic        tone_out, tone_out_inverted;
  logic [3:0]  reg_addr, src_tick;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic [1:0]  reg_byte_en;
  int          error_cnt, checks_done, cycles, rises, high_cycles, n, c;
  time         t0;

  // high-speed source marked absent so its selection can be refused
  sga_top #(.SOURCE_PRESENT(4'hb)) dut (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_byte_en(reg_byte_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_tick(src_tick), .debug_mode(debug_mode), .tone_out(tone_out),
    .tone_out_inverted(tone_out_inverted));
  sga_buzzer_model buzzer (
    .ref_clk(ref_clk), .clr(clr), .tone_out(tone_out),
    .tone_out_inverted(tone_out_inverted), .rises(rises), .high_cycles(high_cycles));

  always #2.5 ref_clk = ~ref_clk;
  // whole run needs about 3100 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report;
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] be = 2'h3);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_byte_en <= be;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask
  task automatic zero;
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    t0 = $time;
  endtask
  // polls a flag bit; c is cycles since the last zero
  task automatic wait_bit(input int b, input logic val);
    int k;
    k = 0;
    do begin
      rd(AF);
      k++;
    end while (v[b] !== val && k < 3000);
    c = int'(($time - t0) / 5);
    `CHK(v[b], val)
  endtask
  task automatic dbg(input logic x);
    @(posedge ref_clk);
    debug_mode <= x;
  endtask

  task automatic t_regs;
    rd(AD); `CHK(v, 16'h00ff)
    rd(AF); `CHK(v, 16'h0002)
    wr(AD, 16'h1234, 2'h1);
    rd(AD); `CHK(v, 16'h00ff)
    rd(AF); `CHK(v, 16'h0002)
    rd(4'hc); `CHK(v, 16'h0000)
    for (int m = 0; m < 3; m++) begin
      wr(AM, 16'(m));
      rd(AM); `CHK(v, 16'(m))
    end
    wr(AM, 16'hffff);
    rd(AM); `CHK(v, 16'h0f06)
    wr(AT, 16'hfefe);
    rd(AT); `CHK(v, 16'h0000)
  endtask
  task automatic t_clock;
    wr(AC, 16'hffff);
    rd(AC); `CHK(v, 16'h0173)
    wr(AC, 16'h0002);
    rd(AC); `CHK(v, 16'h0003)
    wr(AC, 16'h0071);
    rd(AC); `CHK(v, 16'h0071)
    wr(AT, 16'h0001);
    wr(AC, 16'h0000);
    rd(AC); `CHK(v, 16'h0071)
    wr(AT, 16'h0000);
  endtask
  // internal source divided by 4: 193 ticks become 772 cycles
  task automatic t_oneshot;
    wr(AC, 16'h0000);
    wr(AM, 16'h0005);
    wr(AT, 16'h0001);
    zero();
    wr(AD, 16'h0103);
    // load waits for the next divided tick, so busy may still read 0 at first
    wait_bit(8, 1'b1);
    wait_bit(8, 1'b0);
    `CHK(c inside {[772:792]}, 1'b1)
    `CHK(rises inside {[47:49]}, 1'b1)
    `CHK(high_cycles inside {[376:396]}, 1'b1)
    rd(AF); `CHK(v, 16'h0003)
    wr(AF, 16'h0001);
    rd(AF); `CHK(v, 16'h0002)
  endtask
  task automatic t_normal;
    wr(AT, 16'h0000);
    wr(AC, 16'h0071);
    wr(AM, 16'h0000);
    wr(AT, 16'h0001);
    zero();
    wr(AD, 16'h1f3f);
    n = 0;
    repeat (300) @(negedge ref_clk) n += int'(tone_out_inverted !== 1'b0);
    `CHK(n, 0)
    `CHK(rises inside {[4:5]}, 1'b1)
    wr(AM, 16'h0004);
    repeat (3) @(posedge ref_clk);
    n = 0;
    repeat (100) @(negedge ref_clk) n += int'(tone_out_inverted !== ~tone_out);
    `CHK(n, 0)
    wr(AD, 16'h1f3f);
    wr(AT, 16'h0101);
    repeat (200) @(posedge ref_clk);
    rd(AF); `CHK(v[8:1], 8'h81)
    // debug stall freezes the waveform so the stop flag cannot clear early
    dbg(1'b1);
    wr(AT, 16'h0101);
    rd(AT); `CHK(v, 16'h0101)
    zero();
    dbg(1'b0);
    wait_bit(8, 1'b0);
    `CHK(c inside {[1:80]}, 1'b1)
    rd(AT); `CHK(v, 16'h0001)
  endtask
  task automatic t_melody;
    wr(AT, 16'h0000);
    wr(AM, 16'h0006);
    wr(AT, 16'h0001);
    zero();
    wr(AD, 16'h8007);
    repeat (40) @(posedge ref_clk);
    `CHK(rises > 0, 1'b1)
    wr(AD, 16'h4000);
    wait_bit(1, 1'b1);
    `CHK(c inside {[512:530]}, 1'b1)
    repeat (3) @(posedge ref_clk);
    zero();
    n = 0;
    repeat (100) @(negedge ref_clk) n += int'({tone_out, tone_out_inverted} !== 2'b01);
    `CHK(n, 0)
    `CHK(rises, 0)
    // rest of 512 ticks began about seven cycles before the counter zero
    wait_bit(8, 1'b0);
    `CHK(c inside {[500:515]}, 1'b1)
    rd(AF); `CHK(v, 16'h0003)
  endtask
  task automatic t_gate;
    wr(AT, 16'h0000);
    wr(AM, 16'h0005);
    wr(AD, 16'h0103);
    repeat (20) @(posedge ref_clk);
    rd(AF); `CHK(v, 16'h0000)
    dbg(1'b1);
    wr(AT, 16'h0001);
    repeat (20) @(posedge ref_clk);
    rd(AF); `CHK(v, 16'h0000)
    dbg(1'b0);
    repeat (5) @(posedge ref_clk);
    rd(AF); `CHK(v, 16'h0102)
    wait_bit(8, 1'b0);
    wr(AT, 16'h0000);
    wr(AC, 16'h0171);
    wr(AT, 16'h0001);
    dbg(1'b1);
    zero();
    wr(AD, 16'h0103);
    repeat (5) @(posedge ref_clk);
    rd(AF); `CHK(v[8:1], 8'h81)
    wait_bit(8, 1'b0);
    `CHK(c inside {[193:205]}, 1'b1)
    dbg(1'b0);
  endtask

  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_byte_en = 2'h3;
    src_tick = 4'hf;
    debug_mode = 1'b0;
    clr = 1'b1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    clr <= 1'b0;
    t_regs();
    t_clock();
    t_oneshot();
    t_normal();
    t_melody();
    t_gate();
    final_report();
  end
endmodule

// [dv/sga_buzzer_model.sv]
`timescale 1ns/10ps
// passive buzzer: counts rising tone edges and high cycles for the bench
module sga_buzzer_model (
  // clock and counter clear
  input  wire logic ref_clk,
  input  wire logic clr,
  // buzzer pins
  input  wire logic tone_out,
  input  wire logic tone_out_inverted,
  // what the buzzer heard
  output int        rises,
  output int        high_cycles
);
  logic last;

  always @(posedge ref_clk) begin
    last <= tone_out;
    if (clr) begin
      rises <= 0;
      high_cycles <= 0;
    end else begin
      if (tone_out && !last) begin
        rises <= rises + 1;
      end
      if (tone_out) begin
        high_cycles <= high_cycles + 1;
      end
    end
  end
endmodule

// [logic/sga_pkg.sv]
package sga_pkg;

  // register addresses on the plain register port
  localparam logic [3:0] ADDR_CLOCK = 4'h0;
  localparam logic [3:0] ADDR_MODE  = 4'h2;
  localparam logic [3:0] ADDR_CTRL  = 4'h4;
  localparam logic [3:0] ADDR_DATA  = 4'h6;
  localparam logic [3:0] ADDR_FLAG  = 4'h8;

  // sound_clock_control fields
  localparam int CLK_SRC_LSB   = 0;
  localparam int CLK_DIV_LSB   = 4;
  localparam int CLK_DEBUG_RUN_BIT = 8;
  // sound_mode_select fields
  localparam int MODE_FIELD_LSB = 0;
  localparam int MODE_DRIVE_BIT = 2;
  localparam int MODE_TEMPO_LSB = 8;
  // sound_control fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_STOP_BIT = 8;
  // sound_flag_reg fields
  localparam int FLAG_DONE_BIT  = 0;
  localparam int FLAG_EMPTY_BIT = 1;
  localparam int FLAG_BUSY_BIT  = 8;

  // clock sources
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_LOW_XTAL = 2'h1;
  localparam logic [1:0] SRC_HIGH_OSC = 2'h2;
  localparam logic [1:0] SRC_EXTERNAL = 2'h3;
  localparam logic [2:0] DIV_MAX_FAST = 3'h5;
  localparam logic [2:0] DIV_BYPASS   = 3'h7;
  localparam logic [7:0] DIV_BASE     = 8'h04;

  // sound timing in operating-clock ticks
  localparam logic [20:0] ONESHOT_BASE_TICKS = 21'd193;
  localparam logic [20:0] TEMPO_UNIT_TICKS   = 21'd512;

  localparam logic [7:0] PITCH_RESET = 8'hff;

  typedef enum logic [1:0] {
    SGA_MODE_NORMAL  = 2'b00,
    SGA_MODE_ONESHOT = 2'b01,
    SGA_MODE_MELODY  = 2'b10,
    SGA_MODE_RSVD    = 2'b11
  } sga_mode_t;

  typedef enum logic [1:0] {
    SGA_IDLE = 2'b00,
    SGA_PLAY = 2'b01
  } sga_state_t;

  typedef struct packed {
    logic       tie_flag;
    logic       rest_select;
    logic [5:0] duration_duty_field;
    logic [7:0] pitch_field;
  } sga_entry_t;

endpackage

// [logic/sga_top.sv]
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
// Behaviour
// - debug_run keeps operating clock during debug
// - divider codes divide fast sources by 4..128; slow sources need bypass 0x7
// - two-bit field picks the clock source
// - absent clock sources cannot be selected
// - clock settings change only while disabled
// - timing field sets tempo or one-shot length
// - drive-mode bit: normal or direct drive
// - mode field: normal, one-shot, melody; 0x3 reserved
// - stop bit reads 1 until stopping finishes
// - stop ends normal mode, aborts others
// - pending buffer data loads after stopped waveform
// - module enable gates the operating clock
// - data write starts sound; pitch resets 0xff
// - tie joins notes in melody mode only
// - tie on first melody note is ignored
// - rest bit turns melody entry silent
// - rest holds output low, inverted high
// - data write clears empty; load sets empty, busy
// - empty set on load/stop; done set on finish
module sga_top #(
  parameter logic [3:0] SOURCE_PRESENT = 4'hf
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic [1:0]  reg_byte_en,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // clock source ticks and debug state
  input  wire logic [3:0]  src_tick,
  input  wire logic        debug_mode,
  // buzzer pins
  output logic             tone_out,
  output logic             tone_out_inverted
);

  logic [1:0]       clock_source_sel;
  logic [2:0]       clock_divider_sel;
  logic             debug_run;
  sga_pkg::sga_mode_t sound_mode_field;
  logic             drive_mode_sel;
  logic [3:0]       tempo_duration_sel;
  logic             module_enable;
  logic             stop_request;
  sga_pkg::sga_entry_t buffer;
  logic             buf_valid;
  logic             buffer_empty_flag;
  logic             output_done_flag;
  sga_pkg::sga_state_t state;
  sga_pkg::sga_entry_t tone;
  logic             tie_ok;
  logic [7:0]       div_cnt;
  logic [7:0]       phase;
  logic [20:0]      dur_cnt;
  logic             op_tick;
  logic             wr_clock;
  logic             wr_mode;
  logic             wr_ctrl;
  logic             wr_data;
  logic             wr_flag;
  logic             do_load;
  logic             do_finish;
  logic             wave_end;
  logic             note_end;
  logic             wave_high;
  logic [7:0]       next_div_limit;
  logic [7:0]       period;
  logic [20:0]      note_len;
  logic             src_now;
  logic             clock_ok;

  assign wr_clock = reg_wr && (reg_addr == sga_pkg::ADDR_CLOCK);
  assign wr_mode  = reg_wr && (reg_addr == sga_pkg::ADDR_MODE);
  assign wr_ctrl  = reg_wr && (reg_addr == sga_pkg::ADDR_CTRL);
  assign wr_data  = reg_wr && (reg_addr == sga_pkg::ADDR_DATA) && (&reg_byte_en);
  assign wr_flag  = reg_wr && (reg_addr == sga_pkg::ADDR_FLAG);

  // clock control; frozen while enabled so the divider never glitches
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clock_source_sel  <= sga_pkg::SRC_INTERNAL;
      clock_divider_sel <= '0;
      debug_run         <= 1'b0;
    end else if (wr_clock && !module_enable) begin
      if (SOURCE_PRESENT[reg_wdata[sga_pkg::CLK_SRC_LSB +: 2]]) begin
        clock_source_sel <= reg_wdata[sga_pkg::CLK_SRC_LSB +: 2];
      end
      clock_divider_sel <= reg_wdata[sga_pkg::CLK_DIV_LSB +: 3];
      debug_run         <= reg_wdata[sga_pkg::CLK_DEBUG_RUN_BIT];
    end
  end

  // mode select; reserved mode code is refused
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sound_mode_field   <= sga_pkg::SGA_MODE_NORMAL;
      drive_mode_sel     <= 1'b0;
      tempo_duration_sel <= '0;
    end else if (wr_mode) begin
      if (reg_wdata[sga_pkg::MODE_FIELD_LSB +: 2] != sga_pkg::SGA_MODE_RSVD) begin
        sound_mode_field <= sga_pkg::sga_mode_t'(reg_wdata[sga_pkg::MODE_FIELD_LSB +: 2]);
      end
      drive_mode_sel     <= reg_wdata[sga_pkg::MODE_DRIVE_BIT];
      tempo_duration_sel <= reg_wdata[sga_pkg::MODE_TEMPO_LSB +: 4];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      module_enable <= 1'b0;
    end else if (wr_ctrl) begin
      module_enable <= reg_wdata[sga_pkg::CTRL_EN_BIT];
    end
  end

  // stop request: set wins; a load of pending data completes the stop
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stop_request <= 1'b0;
    end else if (wr_ctrl && reg_wdata[sga_pkg::CTRL_STOP_BIT]) begin
      stop_request <= 1'b1;
    end else if (do_finish || do_load || (state == sga_pkg::SGA_IDLE && !buf_valid)
                 || !module_enable) begin
      stop_request <= 1'b0;
    end
  end

  // divider: fast sources divide by 4 << code, slow ones pass only on bypass
  always_comb begin
    src_now        = src_tick[clock_source_sel];
    next_div_limit = sga_pkg::DIV_BASE << clock_divider_sel;
    clock_ok       = 1'b0;
    if (clock_source_sel == sga_pkg::SRC_LOW_XTAL || clock_source_sel == sga_pkg::SRC_EXTERNAL) begin
      clock_ok       = (clock_divider_sel == sga_pkg::DIV_BYPASS);
      next_div_limit = 8'h01;
    end else begin
      clock_ok = (clock_divider_sel <= sga_pkg::DIV_MAX_FAST);
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div_cnt <= '0;
    end else if (!module_enable) begin
      div_cnt <= '0;
    end else if (src_now && (!debug_mode || debug_run)) begin
      div_cnt <= (div_cnt + 8'h01 >= next_div_limit) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  // operating clock exists only while enabled and not halted by debug
  assign op_tick = module_enable && clock_ok && src_now && (!debug_mode || debug_run)
                   && (div_cnt + 8'h01 >= next_div_limit);

  // tone timing from the loaded entry
  always_comb begin
    if (sound_mode_field == sga_pkg::SGA_MODE_MELODY) begin
      period    = tone.pitch_field + 8'h01;
      wave_high = phase < {1'b0, period[7:1]};
      note_len  = 21'((tone.duration_duty_field + 7'h01) * (tempo_duration_sel + 5'h01)
                      * sga_pkg::TEMPO_UNIT_TICKS);
    end else begin
      period    = {2'b00, tone.pitch_field[5:0]} + 8'h01;
      wave_high = phase < ({2'b00, tone.duration_duty_field} + 8'h01);
      note_len  = sga_pkg::ONESHOT_BASE_TICKS
                  + 21'(tempo_duration_sel * sga_pkg::TEMPO_UNIT_TICKS);
    end
  end

  assign wave_end = (phase + 8'h01 >= period);
  assign note_end = (dur_cnt + 21'h1 >= note_len);

  always_comb begin
    do_load   = 1'b0;
    do_finish = 1'b0;
    if (op_tick) begin
      if (state == sga_pkg::SGA_IDLE) begin
        do_load = buf_valid;
      end else if (stop_request && wave_end) begin
        do_load   = buf_valid;
        do_finish = !buf_valid;
      end else if (sound_mode_field == sga_pkg::SGA_MODE_ONESHOT && note_end) begin
        do_finish = 1'b1;
      end else if (sound_mode_field == sga_pkg::SGA_MODE_MELODY && note_end) begin
        do_load   = buf_valid;
        do_finish = !buf_valid;
      end
    end
  end

  // one-entry sound buffer
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      buffer    <= '{tie_flag: 1'b0, rest_select: 1'b0, duration_duty_field: 6'h00,
                     pitch_field: sga_pkg::PITCH_RESET};
      buf_valid <= 1'b0;
    end else if (wr_data) begin
      buffer    <= sga_pkg::sga_entry_t'(reg_wdata);
      buf_valid <= 1'b1;
    end else if (do_load) begin
      buf_valid <= 1'b0;
    end
  end

  // empty flag: a fresh write keeps the buffer honest, so it beats a load
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      buffer_empty_flag <= 1'b1;
    end else if (wr_data) begin
      buffer_empty_flag <= 1'b0;
    end else if (do_load || (wr_ctrl && reg_wdata[sga_pkg::CTRL_STOP_BIT])) begin
      buffer_empty_flag <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      output_done_flag <= 1'b0;
    end else if (do_finish) begin
      output_done_flag <= 1'b1;
    end else if (wr_data || (wr_flag && reg_wdata[sga_pkg::FLAG_DONE_BIT])) begin
      output_done_flag <= 1'b0;
    end
  end

  // sound sequencer
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state   <= sga_pkg::SGA_IDLE;
      tone    <= '{tie_flag: 1'b0, rest_select: 1'b0, duration_duty_field: 6'h00,
                   pitch_field: sga_pkg::PITCH_RESET};
      tie_ok  <= 1'b0;
      phase   <= '0;
      dur_cnt <= '0;
    end else if (!module_enable) begin
      state   <= sga_pkg::SGA_IDLE;
      tie_ok  <= 1'b0;
      phase   <= '0;
      dur_cnt <= '0;
    end else if (do_load) begin
      state   <= sga_pkg::SGA_PLAY;
      tone    <= buffer;
      dur_cnt <= '0;
      tie_ok  <= 1'b1;
      // keep waveform phase across a tie; first note never ties
      if (!(sound_mode_field == sga_pkg::SGA_MODE_MELODY && buffer.tie_flag
            && tie_ok && state == sga_pkg::SGA_PLAY)) begin
        phase <= '0;
      end else begin
        phase <= wave_end ? 8'h00 : phase + 8'h01;
      end
    end else if (do_finish) begin
      state   <= sga_pkg::SGA_IDLE;
      tie_ok  <= 1'b0;
      phase   <= '0;
      dur_cnt <= '0;
    end else if (op_tick && state == sga_pkg::SGA_PLAY) begin
      phase   <= wave_end ? 8'h00 : phase + 8'h01;
      dur_cnt <= dur_cnt + 21'h1;
    end
  end

  // pin drive
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tone_out          <= 1'b0;
      tone_out_inverted <= 1'b0;
    end else if (state != sga_pkg::SGA_PLAY) begin
      tone_out          <= 1'b0;
      tone_out_inverted <= 1'b0;
    end else if (sound_mode_field == sga_pkg::SGA_MODE_MELODY && tone.rest_select) begin
      tone_out          <= 1'b0;
      tone_out_inverted <= 1'b1;
    end else begin
      tone_out          <= wave_high;
      tone_out_inverted <= drive_mode_sel ? !wave_high : 1'b0;
    end
  end

  // read port; unmapped addresses and reserved bits read zero
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      if (reg_addr == sga_pkg::ADDR_CLOCK) begin
        reg_rdata[sga_pkg::CLK_SRC_LSB +: 2] <= clock_source_sel;
        reg_rdata[sga_pkg::CLK_DIV_LSB +: 3] <= clock_divider_sel;
        reg_rdata[sga_pkg::CLK_DEBUG_RUN_BIT]    <= debug_run;
      end else if (reg_addr == sga_pkg::ADDR_MODE) begin
        reg_rdata[sga_pkg::MODE_FIELD_LSB +: 2] <= sound_mode_field;
        reg_rdata[sga_pkg::MODE_DRIVE_BIT]      <= drive_mode_sel;
        reg_rdata[sga_pkg::MODE_TEMPO_LSB +: 4] <= tempo_duration_sel;
      end else if (reg_addr == sga_pkg::ADDR_CTRL) begin
        reg_rdata[sga_pkg::CTRL_EN_BIT]   <= module_enable;
        reg_rdata[sga_pkg::CTRL_STOP_BIT] <= stop_request;
      end else if (reg_addr == sga_pkg::ADDR_DATA) begin
        reg_rdata <= buffer;
      end else if (reg_addr == sga_pkg::ADDR_FLAG) begin
        reg_rdata[sga_pkg::FLAG_DONE_BIT]  <= output_done_flag;
        reg_rdata[sga_pkg::FLAG_EMPTY_BIT] <= buffer_empty_flag;
        reg_rdata[sga_pkg::FLAG_BUSY_BIT]  <= (state == sga_pkg::SGA_PLAY);
      end
    end
  end

  chk_debug_clock_gate: assert property (@(posedge ref_clk) disable iff (reset)
    (module_enable && debug_mode && !debug_run) |=> ($stable(phase) && $stable(dur_cnt)
                                                     && $stable(state)))
    else $error("sound advanced while debug withheld clock");

  chk_enable_gates_tick: assert property (@(posedge ref_clk) disable iff (reset)
    !module_enable |=> (state == sga_pkg::SGA_IDLE && phase == 8'h00 && dur_cnt == 21'h0))
    else $error("sequencer ran while disabled");

  chk_fast_divide_min: assert property (@(posedge ref_clk) disable iff (reset)
    (op_tick && !wr_ctrl && (clock_source_sel == sga_pkg::SRC_INTERNAL
                             || clock_source_sel == sga_pkg::SRC_HIGH_OSC))
    |=> (!op_tick) [*3])
    else $error("fast source divided by less than four");

  chk_stop_ends_wave: assert property (@(posedge ref_clk) disable iff (reset)
    (op_tick && state == sga_pkg::SGA_PLAY && stop_request && wave_end && !buf_valid
     && !wr_ctrl) |=> (state == sga_pkg::SGA_IDLE && !stop_request))
    else $error("stop did not end output at waveform end");

  chk_stop_loads_pending: assert property (@(posedge ref_clk) disable iff (reset)
    (op_tick && state == sga_pkg::SGA_PLAY && stop_request && wave_end && buf_valid
     && !wr_ctrl && !wr_data)
    |=> (state == sga_pkg::SGA_PLAY && !stop_request && buffer_empty_flag))
    else $error("pending entry not loaded after stop");

  chk_direct_drive_low: assert property (@(posedge ref_clk) disable iff (reset)
    (!drive_mode_sel && !(sound_mode_field == sga_pkg::SGA_MODE_MELODY && tone.rest_select))
    |=> !tone_out_inverted)
    else $error("inverted pin driven in direct mode");

  chk_clock_frozen_enabled: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_clock && module_enable) |=> ($stable(clock_source_sel) && $stable(clock_divider_sel)
                                     && $stable(debug_run)))
    else $error("clock settings changed while enabled");

  chk_mode_rsvd_refused: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 sound_mode_field != sga_pkg::SGA_MODE_RSVD)
    else $error("reserved sound mode stored");

  chk_byte_write_ignored: assert property (@(posedge ref_clk) disable iff (reset)
    (reg_wr && reg_addr == sga_pkg::ADDR_DATA && !(&reg_byte_en)) |=> $stable(buffer))
    else $error("byte write changed sound buffer");

  chk_data_write_flags: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_data && !do_finish) |=> (!buffer_empty_flag && buf_valid && !output_done_flag))
    else $error("data write did not arm buffer");

  chk_load_sets_busy: assert property (@(posedge ref_clk) disable iff (reset)
    (do_load && !wr_data) |=> (state == sga_pkg::SGA_PLAY && buffer_empty_flag))
    else $error("load did not set busy and empty");

  chk_stop_reads_one: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_ctrl && reg_wdata[sga_pkg::CTRL_STOP_BIT]) |=> stop_request)
    else $error("stop write not reflected");

  chk_rest_pin_levels: assert property (@(posedge ref_clk) disable iff (reset)
    (state == sga_pkg::SGA_PLAY && sound_mode_field == sga_pkg::SGA_MODE_MELODY
     && tone.rest_select && module_enable) |=> (!tone_out && tone_out_inverted))
    else $error("rest did not hold pins");

  chk_finish_sets_done: assert property (@(posedge ref_clk) disable iff (reset)
    do_finish |=> (output_done_flag && state == sga_pkg::SGA_IDLE))
    else $error("finish did not set done");

endmodule
